// file: hw/gtp_pkg.sv
`default_nettype none
package gtp_pkg;
  // ==========================================
  // Register map, byte offsets per timer group
  // ==========================================
  localparam logic [7:0] GTP_OFF_CFG         = 8'h00;
  localparam logic [7:0] GTP_OFF_SNAP_LO     = 8'h04;
  localparam logic [7:0] GTP_OFF_SNAP_HI     = 8'h08;
  localparam logic [7:0] GTP_OFF_SNAP_TRIG   = 8'h0C;
  localparam logic [7:0] GTP_OFF_ALARM_LO    = 8'h10;
  localparam logic [7:0] GTP_OFF_ALARM_HI    = 8'h14;
  localparam logic [7:0] GTP_OFF_RELOAD_LO   = 8'h18;
  localparam logic [7:0] GTP_OFF_RELOAD_HI   = 8'h1C;
  localparam logic [7:0] GTP_OFF_RELOAD_TRIG = 8'h20;
  localparam logic [7:0] GTP_TIMER_STRIDE    = 8'h24;
  localparam logic [7:0] GTP_OFF_INT_ENA     = 8'h98;
  localparam logic [7:0] GTP_OFF_INT_RAW     = 8'h9C;
  localparam logic [7:0] GTP_OFF_INT_ST      = 8'hA0;
  localparam logic [7:0] GTP_OFF_INT_CLR     = 8'hA4;
  // ==========================================
  // Config word field positions
  // ==========================================
  localparam int GTP_BIT_COUNT_EN  = 31;
  localparam int GTP_BIT_UP        = 30;
  localparam int GTP_BIT_AUTORLD   = 29;
  localparam int GTP_DIV_MSB       = 28;
  localparam int GTP_DIV_LSB       = 13;
  localparam int GTP_BIT_PULSE_EN  = 12;
  localparam int GTP_BIT_LEVEL_EN  = 11;
  localparam int GTP_BIT_ALARM_EN  = 10;
  // Interrupt flag positions
  localparam int GTP_IRQ_T0  = 0;
  localparam int GTP_IRQ_T1  = 1;
  localparam int GTP_IRQ_WDT = 2;
  // ==========================================
  // Reset values and fixed sizes
  // ==========================================
  localparam logic [15:0] GTP_DIV_RESET   = 16'h0001;
  localparam logic [31:0] GTP_WORD_RESET  = 32'h0000_0000;
  localparam logic [2:0]  GTP_IRQ_RESET   = 3'h0;
  localparam int          GTP_NUM_TIMERS  = 2;
  // Timer configuration carried as one bundle
  typedef struct packed {
    logic        count_enable;
    logic        count_up_select;
    logic        reload_on_alarm;
    logic [15:0] prescale_divisor;
    logic        alarm_pulse_irq_enable;
    logic        alarm_level_irq_enable;
    logic        alarm_enable;
  } gtp_cfg_t;
endpackage
`default_nettype wire

// file: hw/gtp_timer_unit.sv
`timescale 1ns/1ps
`default_nettype none
module gtp_timer_unit (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Settings from the register file
  input  wire gtp_pkg::gtp_cfg_t cfg,
  input  wire logic [63:0]       reload_value,
  input  wire logic [63:0]       alarm_value,
  // Write strobes, one cycle each
  input  wire logic              instant_reload,
  input  wire logic              snapshot_trigger,
  // Results
  output logic [63:0]            snapshot,
  output logic                   alarm_event
);
  import gtp_pkg::*;

  logic [63:0] count;     // Time-base counter
  logic [15:0] pre_cnt;   // Prescaler phase
  logic        hit_d;     // Compare result, last cycle
  logic [15:0] div_m1;    // Decoded divisor minus one
  logic        tick;      // Prescaled tick
  logic        hit;       // Compare result now
  logic        alarm_now; // First cycle of a hit
  logic        auto_rld;  // Reload caused by alarm

  // ==========================================
  // Prescaler
  // ==========================================
  // 0 means 65536, 1 and 2 both mean 2
  assign div_m1 = (cfg.prescale_divisor == 16'h0001) ? 16'h0001 :
                  (cfg.prescale_divisor - 16'h0001);
  assign tick   = cfg.count_enable && (pre_cnt == div_m1);

  // Phase restarts while stopped so resume gives a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 16'h0000;
    end else if (!cfg.count_enable || tick) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // ==========================================
  // Alarm compare
  // ==========================================
  // Overshoot counts too, so a late alarm value fires at once
  assign hit = cfg.alarm_enable &&
               (cfg.count_up_select ? (count >= alarm_value)
                                    : (count <= alarm_value));
  assign alarm_now = hit && !hit_d;
  assign auto_rld  = alarm_now && cfg.reload_on_alarm;

  // Event on the rising compare, so a parked overshoot fires once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_d       <= 1'b0;
      alarm_event <= 1'b0;
    end else begin
      hit_d       <= hit;
      alarm_event <= alarm_now;
    end
  end

  // ==========================================
  // Counter: reload beats counting
  // ==========================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 64'h0000_0000_0000_0000;
    end else if (instant_reload || auto_rld) begin
      count <= reload_value;
    end else if (tick) begin
      count <= cfg.count_up_select ? count + 64'h1 : count - 64'h1;
    end
  end

  // Snapshot holds until the next trigger
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snapshot <= 64'h0000_0000_0000_0000;
    end else if (snapshot_trigger) begin
      snapshot <= count;
    end
  end

  // ==========================================
  // Checks
  // ==========================================
  sequence s_tick_div2;
    tick && (div_m1 == 16'h0001);
  endsequence
  sequence s_still_div2;
    cfg.count_enable && (div_m1 == 16'h0001);
  endsequence
  a_prescale_period: assert property (@(posedge clk) disable iff (!rst_n)
    s_tick_div2 ##1 s_still_div2 [*2] |-> tick && !$past(tick))
    else $error("tick spacing wrong for divide by two");
  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !instant_reload && !auto_rld |=>
      count == ($past(cfg.count_up_select) ? $past(count) + 64'h1 : $past(count) - 64'h1))
    else $error("counter did not step by one");
  a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.count_enable && !instant_reload && !auto_rld |=> $stable(count))
    else $error("counter moved while stopped");
  a_instant_reload: assert property (@(posedge clk) disable iff (!rst_n)
    instant_reload |=> count == $past(reload_value))
    else $error("instant reload not applied");
  a_snapshot_latch: assert property (@(posedge clk) disable iff (!rst_n)
    snapshot_trigger |=> snapshot == $past(count) ##1 $stable(snapshot) || $past(snapshot_trigger))
    else $error("snapshot not latched");
  a_alarm_raise: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.alarm_enable && cfg.count_up_select && (count >= alarm_value) && !hit_d |=> alarm_event)
    else $error("alarm missed on compare");
  a_alarm_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.alarm_enable |=> !alarm_event)
    else $error("alarm while disabled");
endmodule // gtp_timer_unit
`default_nettype wire

// file: hw/gtp_timer_group.sv
`timescale 1ns/1ps
`default_nettype none
module gtp_timer_group (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Watchdog stage timeout, same clock
  input  wire logic        wdt_stage_timeout,
  // Interrupt lines
  output logic [1:0]       alarm_level_irq,
  output logic [1:0]       alarm_pulse_irq,
  output logic             watchdog_irq
);
  import gtp_pkg::*;
  // Checks below run on clk and sleep during reset
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // Bus handshake
  // ==========================================
  logic        accept;        // Edge where the master samples the answer
  logic        wr_acc;        // Write takes effect now
  logic [31:0] next_readdata; // Read data chosen at request
  logic [31:0] be_mask;       // Byte lanes as bit mask

  assign accept = (read || write) && !waitrequest;
  assign wr_acc = write && accept;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  // One wait cycle per access; read data are ready with the low waitrequest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Read data captured in the wait cycle, held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= GTP_WORD_RESET;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ==========================================
  // Interrupt flags
  // ==========================================
  logic [2:0] irq_raw;    // Sticky raw flags
  logic [2:0] irq_ena;    // Per-flag enable
  logic [2:0] irq_set;    // Events this cycle
  logic [2:0] irq_clr;    // Write-one clears this cycle
  logic [2:0] irq_st;     // Masked view
  logic [1:0] alarm_evt;  // Alarm events from the timers

  assign irq_set = {wdt_stage_timeout, alarm_evt};
  assign irq_clr = (wr_acc && address == GTP_OFF_INT_CLR) ?
                   (writedata[2:0] & be_mask[2:0]) : 3'h0;
  assign irq_st  = irq_raw & irq_ena;

  // A set in the same cycle as its clear survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_raw <= GTP_IRQ_RESET;
    end else begin
      irq_raw <= (irq_raw & ~irq_clr) | irq_set;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ena <= GTP_IRQ_RESET;
    end else if (wr_acc && address == GTP_OFF_INT_ENA) begin
      irq_ena <= (irq_ena & ~be_mask[2:0]) | (writedata[2:0] & be_mask[2:0]);
    end
  end

  // ==========================================
  // Per-timer registers and units
  // ==========================================
  gtp_cfg_t    cfg      [GTP_NUM_TIMERS]; // Decoded config
  logic [31:0] cfg_word [GTP_NUM_TIMERS]; // Config as stored
  logic [63:0] alarm_v  [GTP_NUM_TIMERS]; // Alarm compare value
  logic [63:0] reload_v [GTP_NUM_TIMERS]; // Load value
  logic [63:0] snap     [GTP_NUM_TIMERS]; // Snapshot words
  logic [1:0]  lvl_next;                  // Level lines next value
  logic [1:0]  pls_next;                  // Pulse lines next value

  genvar t;
  generate
    for (t = 0; t < GTP_NUM_TIMERS; t++) begin : g_timer
      localparam logic [7:0] BASE = 8'(t * GTP_TIMER_STRIDE);
      logic wr_cfg;  // Config write
      logic wr_alo;  // Alarm low write
      logic wr_ahi;  // Alarm high write
      logic wr_rlo;  // Load low write
      logic wr_rhi;  // Load high write
      logic rld_go;  // Instant reload strobe
      logic snp_go;  // Snapshot strobe

      assign wr_cfg = wr_acc && (address == BASE + GTP_OFF_CFG);
      assign wr_alo = wr_acc && (address == BASE + GTP_OFF_ALARM_LO);
      assign wr_ahi = wr_acc && (address == BASE + GTP_OFF_ALARM_HI);
      assign wr_rlo = wr_acc && (address == BASE + GTP_OFF_RELOAD_LO);
      assign wr_rhi = wr_acc && (address == BASE + GTP_OFF_RELOAD_HI);
      // Any value written fires the strobe; byte lanes do not matter
      assign rld_go = wr_acc && (address == BASE + GTP_OFF_RELOAD_TRIG);
      assign snp_go = wr_acc && (address == BASE + GTP_OFF_SNAP_TRIG);

      // Config fields unpacked from the stored word
      assign cfg[t].count_enable           = cfg_word[t][GTP_BIT_COUNT_EN];
      assign cfg[t].count_up_select        = cfg_word[t][GTP_BIT_UP];
      assign cfg[t].reload_on_alarm        = cfg_word[t][GTP_BIT_AUTORLD];
      assign cfg[t].prescale_divisor       = cfg_word[t][GTP_DIV_MSB:GTP_DIV_LSB];
      assign cfg[t].alarm_pulse_irq_enable = cfg_word[t][GTP_BIT_PULSE_EN];
      assign cfg[t].alarm_level_irq_enable = cfg_word[t][GTP_BIT_LEVEL_EN];
      assign cfg[t].alarm_enable           = cfg_word[t][GTP_BIT_ALARM_EN];

      // Writable words; load value writes only store, the counter takes them on a reload
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_word[t] <= {GTP_WORD_RESET[31:29], GTP_DIV_RESET, GTP_WORD_RESET[12:0]};
          alarm_v[t]  <= {GTP_WORD_RESET, GTP_WORD_RESET};
          reload_v[t] <= {GTP_WORD_RESET, GTP_WORD_RESET};
        end else begin
          if (wr_cfg) begin
            cfg_word[t] <= (cfg_word[t] & ~be_mask) | (writedata & be_mask);
          end
          if (wr_alo) begin
            alarm_v[t][31:0] <= (alarm_v[t][31:0] & ~be_mask) | (writedata & be_mask);
          end
          if (wr_ahi) begin
            alarm_v[t][63:32] <= (alarm_v[t][63:32] & ~be_mask) | (writedata & be_mask);
          end
          if (wr_rlo) begin
            reload_v[t][31:0] <= (reload_v[t][31:0] & ~be_mask) | (writedata & be_mask);
          end
          if (wr_rhi) begin
            reload_v[t][63:32] <= (reload_v[t][63:32] & ~be_mask) | (writedata & be_mask);
          end
        end
      end

      // Counter, prescaler, compare and snapshot
      gtp_timer_unit u_unit (
        .clk              (clk),
        .rst_n            (rst_n),
        .cfg              (cfg[t]),
        .reload_value     (reload_v[t]),
        .alarm_value      (alarm_v[t]),
        .instant_reload   (rld_go),
        .snapshot_trigger (snp_go),
        .snapshot         (snap[t]),
        .alarm_event      (alarm_evt[t])
      );

      // Level line follows the sticky flag; pulse line mirrors the event
      assign lvl_next[t] = irq_raw[t] && cfg[t].alarm_level_irq_enable;
      assign pls_next[t] = alarm_evt[t] && cfg[t].alarm_pulse_irq_enable;
    end
  endgenerate

  // ==========================================
  // Interrupt output registers
  // ==========================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_level_irq <= 2'h0;
      alarm_pulse_irq <= 2'h0;
      watchdog_irq    <= 1'b0;
    end else begin
      alarm_level_irq <= lvl_next;
      alarm_pulse_irq <= pls_next;
      watchdog_irq    <= irq_st[GTP_IRQ_WDT];
    end
  end

  // ==========================================
  // Read selection
  // ==========================================
  // Unmapped and write-only addresses read as zero
  always_comb begin
    next_readdata = GTP_WORD_RESET;
    case (address)
      GTP_OFF_CFG:                          next_readdata = cfg_word[0];
      GTP_OFF_SNAP_LO:                      next_readdata = snap[0][31:0];
      GTP_OFF_SNAP_HI:                      next_readdata = snap[0][63:32];
      GTP_OFF_ALARM_LO:                     next_readdata = alarm_v[0][31:0];
      GTP_OFF_ALARM_HI:                     next_readdata = alarm_v[0][63:32];
      GTP_OFF_RELOAD_LO:                    next_readdata = reload_v[0][31:0];
      GTP_OFF_RELOAD_HI:                    next_readdata = reload_v[0][63:32];
      GTP_TIMER_STRIDE + GTP_OFF_CFG:       next_readdata = cfg_word[1];
      GTP_TIMER_STRIDE + GTP_OFF_SNAP_LO:   next_readdata = snap[1][31:0];
      GTP_TIMER_STRIDE + GTP_OFF_SNAP_HI:   next_readdata = snap[1][63:32];
      GTP_TIMER_STRIDE + GTP_OFF_ALARM_LO:  next_readdata = alarm_v[1][31:0];
      GTP_TIMER_STRIDE + GTP_OFF_ALARM_HI:  next_readdata = alarm_v[1][63:32];
      GTP_TIMER_STRIDE + GTP_OFF_RELOAD_LO: next_readdata = reload_v[1][31:0];
      GTP_TIMER_STRIDE + GTP_OFF_RELOAD_HI: next_readdata = reload_v[1][63:32];
      GTP_OFF_INT_ENA:                      next_readdata = {29'h0000_0000, irq_ena};
      GTP_OFF_INT_RAW:                      next_readdata = {29'h0000_0000, irq_raw};
      GTP_OFF_INT_ST:                       next_readdata = {29'h0000_0000, irq_st};
      default:                              next_readdata = GTP_WORD_RESET;
    endcase
  end

  // ==========================================
  // Checks
  // ==========================================
  sequence s_bus_req;
    (read || write) && waitrequest;
  endsequence
  a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
    s_bus_req |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for one cycle");
  a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    irq_set[GTP_IRQ_T0] && irq_clr[GTP_IRQ_T0] |=> irq_raw[GTP_IRQ_T0])
    else $error("event lost under clear");
  a_timer_flags: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_evt[1] && !alarm_evt[0] && !irq_raw[0] && !irq_clr[1] |=> irq_raw[1] && !irq_raw[0])
    else $error("alarm set wrong flag");
  a_wdt_flag: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_stage_timeout |=> irq_raw[GTP_IRQ_WDT])
    else $error("watchdog flag not set");
  a_level_hold: assert property (@(posedge clk) disable iff (!rst_n)
    irq_raw[0] && cfg[0].alarm_level_irq_enable && !irq_clr[0] |=> irq_raw[0] ##0
      (alarm_level_irq[0] || !cfg[0].alarm_level_irq_enable))
    else $error("level interrupt dropped");
  a_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_evt[0] && cfg[0].alarm_pulse_irq_enable |=> alarm_pulse_irq[0] ##1 !alarm_pulse_irq[0])
    else $error("pulse interrupt not one cycle");
  a_status_masked: assert property (@(posedge clk) disable iff (!rst_n)
    read && waitrequest && address == GTP_OFF_INT_ST |=> readdata[2:0] == $past(irq_raw & irq_ena))
    else $error("masked status wrong");

  // Idle bus keeps waitrequest high
  a_bus_idle: assert property (
    !(read || write) |=> waitrequest)
    else $error("waitrequest low while idle");

  // Read data stand until the next read
  a_read_hold: assert property (
    !(read && waitrequest) |=> $stable(readdata))
    else $error("read data changed between reads");

  // A raw status read being taken
  sequence s_read_raw;
    (read && waitrequest && address == GTP_OFF_INT_RAW);
  endsequence

  // Raw status shows the flags of the request cycle
  a_status_raw: assert property (
    s_read_raw |=> readdata[2:0] == $past(irq_raw))
    else $error("raw status wrong");

  // Timer zero event sets its flag
  a_t0_flag: assert property (
    alarm_evt[GTP_IRQ_T0] |=> irq_raw[GTP_IRQ_T0])
    else $error("timer zero flag not set");

  // Timer one event sets its flag
  a_t1_flag: assert property (
    alarm_evt[GTP_IRQ_T1] |=> irq_raw[GTP_IRQ_T1])
    else $error("timer one flag not set");

  // A clear with no event empties the flag
  a_flag_clear: assert property (
    irq_clr[GTP_IRQ_WDT] && !irq_set[GTP_IRQ_WDT] |=> !irq_raw[GTP_IRQ_WDT])
    else $error("flag not cleared");

  // Enabled watchdog flag drives its line
  a_wdt_line: assert property (
    irq_raw[GTP_IRQ_WDT] && irq_ena[GTP_IRQ_WDT] |=> watchdog_irq)
    else $error("watchdog line missing");

  // Level line drops once its flag is gone
  a_level_clear: assert property (
    !irq_raw[GTP_IRQ_T0] |=> !alarm_level_irq[0])
    else $error("level line without flag");

  // Level line quiet while its enable is clear
  a_level_gated: assert property (
    !cfg[1].alarm_level_irq_enable |=> !alarm_level_irq[1])
    else $error("level line while disabled");

  // Timer one pulse follows its event
  a_pulse_t1: assert property (
    alarm_evt[1] && cfg[1].alarm_pulse_irq_enable |=> alarm_pulse_irq[1])
    else $error("timer one pulse missing");

  // Pulse line quiet while its enable is clear
  a_pulse_gated: assert property (
    !cfg[1].alarm_pulse_irq_enable |=> !alarm_pulse_irq[1])
    else $error("pulse line while disabled");

  // No pulse without an alarm event
  a_pulse_event: assert property (
    !alarm_evt[0] |=> !alarm_pulse_irq[0])
    else $error("pulse without event");

  // A full-word config write being taken
  sequence s_cfg_write;
    wr_acc && address == GTP_OFF_CFG && byteenable == 4'hF;
  endsequence

  // Config write lands whole
  a_cfg_write: assert property (
    s_cfg_write |=> cfg_word[0] == $past(writedata))
    else $error("config write lost");

  // Interrupt enable write lands
  a_enable_write: assert property (
    wr_acc && address == GTP_OFF_INT_ENA && byteenable[0] |=> irq_ena == $past(writedata[2:0]))
    else $error("interrupt enable write lost");
endmodule // gtp_timer_group
`default_nettype wire

// file: verif/gtp_timer_group_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gtp_timer_group_bench;
  import gtp_pkg::*;
  // ==========================================
  // Stimulus and observation signals
  // ==========================================
  logic        clk               = 1'b0;
  logic        rst_n             = 1'b0;
  logic [7:0]  address           = 8'h00;
  logic        read              = 1'b0;
  logic        write             = 1'b0;
  logic [31:0] writedata         = 32'h0000_0000;
  logic        wdt_stage_timeout = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        watchdog_irq;
  logic [1:0]  alarm_level_irq;
  logic [1:0]  alarm_pulse_irq;
  logic [31:0] q;               // Last read data
  logic [31:0] v0;              // First snapshot of a pair
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cycles     = 0;  // Hang guard
  int          pulses1    = 0;  // Timer one pulse cycles seen
  // Byte lanes tied on: every access is a full word
  gtp_timer_group i_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .wdt_stage_timeout(wdt_stage_timeout), .alarm_level_irq(alarm_level_irq),
    .alarm_pulse_irq(alarm_pulse_irq), .watchdog_irq(watchdog_irq));
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The whole run needs a few hundred cycles; 20000 means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  // Counts the cycles in which timer one's pulse line is high
  always @(posedge clk) begin
    if (alarm_pulse_irq[1] === 1'b1) pulses1++;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Raised right after an edge, held until the edge where waitrequest is low; not released
  // here so that back-to-back calls keep the bus busy without driving a signal twice
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      results();
    end
    q = readdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic idle(input int n);
    read <= 1'b0;
    write <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // Config word in field order: enable, up, auto-reload, divisor, pulse, level, alarm
  function automatic logic [31:0] cfgw(input logic en, up, ar, pe, le, ae, input logic [15:0] dv);
    cfgw = {en, up, ar, dv, pe, le, ae, 10'h000};
  endfunction
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset;
    rd(GTP_OFF_CFG);
    chk("cfg reset", q, {3'h0, GTP_DIV_RESET, 13'h0000});
    rd(GTP_OFF_INT_RAW);
    chk("raw reset", q, 32'h0000_0000);
    rd(8'h70);
    chk("unmapped read", q, 32'h0000_0000);
    idle(1);
    $display("done: reset");
  endtask
  task automatic t_reload;
    wr(GTP_OFF_RELOAD_LO, 32'h1234_5678);
    wr(GTP_OFF_RELOAD_HI, 32'h0000_00AB);
    wr(GTP_OFF_SNAP_TRIG, 32'h0);
    rd(GTP_OFF_SNAP_LO);
    chk("load untouched", q, 32'h0000_0000);
    wr(GTP_OFF_RELOAD_TRIG, 32'h0);
    wr(GTP_OFF_SNAP_TRIG, 32'h0);
    rd(GTP_OFF_SNAP_LO);
    chk("reload low", q, 32'h1234_5678);
    rd(GTP_OFF_SNAP_HI);
    chk("reload high", q, 32'h0000_00AB);
    idle(1);
    $display("done: reload");
  endtask
  // Snapshots 40 cycles apart, a whole number of prescaled ticks
  task automatic meas(input logic en, up, input logic [15:0] dv, input logic [31:0] exp);
    wr(GTP_OFF_CFG, cfgw(1'b0, up, 1'b0, 1'b0, 1'b0, 1'b0, dv));
    wr(GTP_OFF_CFG, cfgw(en, up, 1'b0, 1'b0, 1'b0, 1'b0, dv));
    wr(GTP_OFF_SNAP_TRIG, 32'h0);
    rd(GTP_OFF_SNAP_LO);
    v0 = q;
    idle(36);
    wr(GTP_OFF_SNAP_TRIG, 32'h0);
    rd(GTP_OFF_SNAP_LO);
    chk("count step", q - v0, exp);
    wr(GTP_OFF_CFG, cfgw(1'b0, up, 1'b0, 1'b0, 1'b0, 1'b0, dv));
    idle(1);
  endtask
  task automatic t_rate;
    meas(1'b1, 1'b1, 16'h0001, 32'd20);
    meas(1'b1, 1'b1, 16'h0000, 32'd0);
    meas(1'b1, 1'b1, 16'h0002, 32'd20);
    meas(1'b1, 1'b1, 16'h0005, 32'd8);
    meas(1'b1, 1'b0, 16'h0004, 32'hFFFF_FFF6);
    meas(1'b0, 1'b1, 16'h0004, 32'd0);
    $display("done: rate");
  endtask
  task automatic t_alarm;
    int n;
    n = 0;
    wr(GTP_OFF_RELOAD_LO, 32'h0);
    wr(GTP_OFF_RELOAD_HI, 32'h0);
    wr(GTP_OFF_RELOAD_TRIG, 32'h0);
    wr(GTP_OFF_ALARM_LO, 32'd10);
    wr(GTP_OFF_CFG, cfgw(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0002));
    idle(0);
    do begin
      @(negedge clk);
      n++;
    end while (alarm_pulse_irq[0] !== 1'b1 && n < 100);
    chk("pulse seen", {31'h0, alarm_pulse_irq[0]}, 32'h1);
    @(negedge clk);
    chk("pulse width", {31'h0, alarm_pulse_irq[0]}, 32'h0);
    chk("level set", {31'h0, alarm_level_irq[0]}, 32'h1);
    @(posedge clk);
    rd(GTP_OFF_INT_ST);
    chk("masked off", q, 32'h0);
    rd(GTP_OFF_INT_RAW);
    chk("raw t0", q, 32'h1);
    wr(GTP_OFF_INT_ENA, 32'h7);
    rd(GTP_OFF_INT_ST);
    chk("masked on", q, 32'h1);
    wr(GTP_OFF_SNAP_TRIG, 32'h0);
    rd(GTP_OFF_SNAP_LO);
    chk("runs past alarm", {31'h0, q > 32'd10}, 32'h1);
    wr(GTP_OFF_INT_CLR, 32'h1);
    rd(GTP_OFF_INT_RAW);
    chk("raw cleared", q, 32'h0);
    chk("level cleared", {31'h0, alarm_level_irq[0]}, 32'h0);
    wr(GTP_OFF_CFG, 32'h0);
    idle(1);
    $display("done: alarm");
  endtask
  task automatic t_overshoot;
    wr(GTP_TIMER_STRIDE + GTP_OFF_RELOAD_LO, 32'd100);
    wr(GTP_TIMER_STRIDE + GTP_OFF_RELOAD_TRIG, 32'h0);
    wr(GTP_TIMER_STRIDE + GTP_OFF_RELOAD_LO, 32'd7);
    wr(GTP_TIMER_STRIDE + GTP_OFF_ALARM_LO, 32'd50);
    wr(GTP_TIMER_STRIDE + GTP_OFF_CFG, cfgw(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0002));
    idle(5);
    rd(GTP_OFF_INT_RAW);
    chk("alarm disabled", q, 32'h0);
    wr(GTP_TIMER_STRIDE + GTP_OFF_CFG, cfgw(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0002));
    idle(5);
    rd(GTP_OFF_INT_RAW);
    chk("raw t1", q, 32'h2);
    chk("pulse t1", pulses1, 32'h1);
    chk("level t1", {30'h0, alarm_level_irq}, 32'h2);
    wr(GTP_TIMER_STRIDE + GTP_OFF_SNAP_TRIG, 32'h0);
    rd(GTP_TIMER_STRIDE + GTP_OFF_SNAP_LO);
    chk("auto reload", q, 32'd7);
    wr(GTP_OFF_INT_CLR, 32'h2);
    wr(GTP_TIMER_STRIDE + GTP_OFF_CFG, 32'h0);
    chk("level t1 off", {30'h0, alarm_level_irq}, 32'h0);
    idle(1);
    $display("done: overshoot");
  endtask
  task automatic t_wdt;
    wdt_stage_timeout <= 1'b1;
    @(posedge clk);
    wdt_stage_timeout <= 1'b0;
    repeat (3) @(posedge clk);
    rd(GTP_OFF_INT_RAW);
    chk("raw wdt", q, 32'h4);
    chk("wdt line", {31'h0, watchdog_irq}, 32'h1);
    wr(GTP_OFF_INT_CLR, 32'h4);
    rd(GTP_OFF_INT_RAW);
    chk("wdt cleared", q, 32'h0);
    chk("wdt line off", {31'h0, watchdog_irq}, 32'h0);
    idle(1);
    $display("done: watchdog");
  endtask
  // Six cycles of reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_reload();
    t_rate();
    t_alarm();
    t_overshoot();
    t_wdt();
    results();
  end
endmodule // gtp_timer_group_bench
`default_nettype wire
